// >>> dv/dpv_panel_model.sv
// Panel model: resolves video pins with their pull-downs, counts horizontal and vertical sync edges.
// Assumes pin levels and enables come from the video output stage.
`timescale 1ns/1ps
module dpv_panel_model (
  // System
  input wire logic clock,
  input wire logic rst,
  // Pins
  input wire dpv_pkg::dpv_vid_pins_s vid_out,
  input wire dpv_pkg::dpv_vid_pins_s vid_oe,
  // Edge counts
  output logic [15:0] hs_cnt,
  output logic [15:0] vs_cnt
);
  dpv_pkg::dpv_vid_pins_s pin;
  dpv_pkg::dpv_vid_pins_s pin_q;
  logic [15:0] next_hs_cnt;
  logic [15:0] next_vs_cnt;
  // Undriven pin falls to its pull-down
  assign pin = vid_out & vid_oe;
  always_comb begin
    next_hs_cnt = hs_cnt + 16'(pin.hs ^ pin_q.hs);
    next_vs_cnt = vs_cnt + 16'(pin.vs ^ pin_q.vs);
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      hs_cnt <= 16'h0;
      vs_cnt <= 16'h0;
      pin_q <= '0;
    end else begin
      hs_cnt <= next_hs_cnt;
      vs_cnt <= next_vs_cnt;
      pin_q <= pin;
    end
  end
endmodule // dpv_panel_model

// >>> dv/dpv_video_out_tb_top.sv
// Testbench for the parallel video output stage.
// Assumes the panel model sits on the video pins; bench is APB master.
`timescale 1ns/1ps
module dpv_video_out_tb_top;
  logic clock, rst, psel, penable, pwrite, pclk_in, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, aud_wc_in, aud_da_in, aud_db_in;
  logic power_down_bar, output_enable_pin, lock_in, mode_select_pin, shared_int_pin;
  logic lock_out, pll_enable, selftest_clock_select;
  logic [3:0] gpio_in;
  logic [15:0] hs_cnt, vs_cnt, h0, v0;
  dpv_pkg::dpv_pixel_s rx_pixel;
  dpv_pkg::dpv_vid_pins_s vid_out, vid_oe;
  dpv_pkg::dpv_aud_pins_s aud_out, aud_oe;
  int errors, comparisons;

  dpv_video_out u_dpv_video_out (.clock, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pclk_in, .rx_pixel, .aud_wc_in, .aud_da_in,
    .aud_db_in, .power_down_bar, .output_enable_pin, .lock_in, .mode_select_pin,
    .shared_int_pin, .gpio_in, .vid_out, .vid_oe, .aud_out, .aud_oe, .lock_out,
    .pll_enable, .selftest_clock_select);
  dpv_panel_model u_dpv_panel_model (.clock, .rst, .vid_out, .vid_oe, .hs_cnt,
    .vs_cnt);

  always #10 clock = ~clock;
  // Link clock, 160 ns, offset from the system clock
  initial begin
    pclk_in = 1'h0;
    #7;
    forever #80 pclk_in = ~pclk_in;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task test_done;
    $display("Counts: errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task wclk(input int n);
    repeat (n) @(posedge clock);
  endtask

  task wpix(input int n);
    repeat (n) @(posedge pclk_in);
    @(posedge clock);
  endtask

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do begin
      @(posedge clock);
      n++;
      if (n > 20) begin
        errors++;
        test_done;
      end
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task t_regs;
    apb(1'h0, dpv_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h2);
    apb(1'h0, dpv_pkg::ADDR_GPO, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, dpv_pkg::ADDR_STAT, 32'h0);
    chk(rd, 32'h3);
    apb(1'h1, 12'h010, 32'hffff_ffff);
    apb(1'h0, 12'h010, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    $display("t_regs done");
  endtask

  task t_lock;
    lock_in <= 1'h0;
    wclk(6);
    chk(vid_oe, 32'h0fff_ffff);
    chk(vid_out, 32'h0);
    output_enable_pin <= 1'h0;
    wclk(6);
    chk(vid_oe, 32'h0);
    lock_in <= 1'h1;
    wclk(6);
    chk(vid_oe, 32'h0fff_ffff);
    chk(lock_out, 32'h1);
    output_enable_pin <= 1'h1;
    power_down_bar <= 1'h0;
    wclk(6);
    chk(vid_oe, 32'h0);
    chk({aud_oe, pll_enable}, 32'h0);
    power_down_bar <= 1'h1;
    wclk(6);
    chk(pll_enable, 32'h1);
    $display("t_lock done");
  endtask

  task t_strobe;
    rx_pixel.data <= 24'ha5c3e1;
    wpix(3);
    chk(vid_out.data, 32'ha5c3e1);
    for (int s = 0; s < 2; s++) begin
      apb(1'h1, dpv_pkg::ADDR_CTRL, 32'h2 | s);
      @(posedge pclk_in);
      wclk(5);
      chk(vid_out.pclk, 32'(s == 0));
    end
    apb(1'h1, dpv_pkg::ADDR_CTRL, 32'h2);
    $display("t_strobe done");
  endtask

  task pulse_hs(input int n);
    rx_pixel.hs <= 1'h1;
    wpix(n);
    rx_pixel.hs <= 1'h0;
    wpix(10);
  endtask

  task t_ctl;
    h0 = hs_cnt;
    pulse_hs(2);
    chk(hs_cnt - h0, 32'h0);
    apb(1'h1, dpv_pkg::ADDR_CTRL, 32'h0);
    pulse_hs(1);
    chk(hs_cnt - h0, 32'h2);
    pulse_hs(1);
    wpix(10);
    chk(hs_cnt - h0, 32'h2);
    apb(1'h1, dpv_pkg::ADDR_CTRL, 32'h2);
    v0 = vs_cnt;
    rx_pixel.vs <= 1'h1;
    wpix(10);
    rx_pixel.vs <= 1'h0;
    wpix(20);
    chk(vs_cnt - v0, 32'h1);
    wpix(120);
    chk(vs_cnt - v0, 32'h2);
    rx_pixel.de <= 1'h1;
    wpix(5);
    chk(vid_out.de, 32'h1);
    rx_pixel.de <= 1'h0;
    $display("t_ctl done");
  endtask

  task t_mux;
    rx_pixel.data <= 24'h0;
    apb(1'h1, dpv_pkg::ADDR_GPIO, 32'hf5);
    wpix(3);
    chk({vid_out.data[9:8], vid_out.data[1:0]}, 32'h0);
    apb(1'h1, dpv_pkg::ADDR_CTRL, 32'h6);
    wclk(6);
    chk({vid_out.data[9:8], vid_out.data[1:0]}, 32'h5);
    apb(1'h1, dpv_pkg::ADDR_CTRL, 32'h2);
    mode_select_pin <= 1'h1;
    gpio_in <= 4'ha;
    aud_db_in <= 1'h1;
    aud_wc_in <= 1'h1;
    aud_da_in <= 1'h1;
    wclk(20);
    chk({vid_out.data[9:8], vid_out.data[1:0]}, 32'h5);
    chk(vid_out.data[17], 32'h1);
    chk({aud_out.wc, aud_out.da}, 32'h3);
    apb(1'h0, dpv_pkg::ADDR_STAT, 32'h0);
    chk(rd, 32'hab);
    apb(1'h1, dpv_pkg::ADDR_GPO, 32'h1f09);
    wclk(6);
    chk({aud_out.bclk, aud_out.wc, aud_out.da, vid_out.data[17:16]}, 32'h9);
    wclk(4);
    chk(aud_out.bclk, 32'h0);
    apb(1'h1, dpv_pkg::ADDR_GPO, 32'h0);
    apb(1'h1, dpv_pkg::ADDR_GPIO, 32'h0);
    mode_select_pin <= 1'h0;
    aud_db_in <= 1'h0;
    aud_wc_in <= 1'h0;
    aud_da_in <= 1'h0;
    $display("t_mux done");
  endtask

  task t_audio;
    int nb, nm;
    logic pb, pm;
    for (int r = 0; r < 3; r++) begin
      apb(1'h1, dpv_pkg::ADDR_CTRL, 32'h2 | (r << 3));
      wclk(16);
      nb = 0;
      nm = 0;
      repeat (64) begin
        pb = aud_out.bclk;
        pm = aud_out.mclk;
        @(posedge clock);
        nb += int'(aud_out.bclk & !pb);
        nm += int'(aud_out.mclk & !pm);
      end
      chk(nb, 32'h8);
      chk(nm, 32'h8 << r);
    end
    shared_int_pin <= 1'h1;
    apb(1'h1, dpv_pkg::ADDR_CTRL, 32'h2);
    wclk(6);
    chk(selftest_clock_select, 32'h1);
    apb(1'h1, dpv_pkg::ADDR_CTRL, 32'h22);
    wclk(6);
    chk(selftest_clock_select, 32'h0);
    apb(1'h0, dpv_pkg::ADDR_STAT, 32'h0);
    chk(rd, 32'h7);
    $display("t_audio done");
  endtask

  initial begin
    clock = 1'h0;
    rst = 1'h1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rx_pixel = '0;
    {aud_wc_in, aud_da_in, aud_db_in, mode_select_pin, shared_int_pin} = '0;
    gpio_in = 4'h0;
    power_down_bar = 1'h1;
    output_enable_pin = 1'h1;
    lock_in = 1'h1;
    errors = 0;
    comparisons = 0;
    wclk(3);
    rst <= 1'h0;
    wclk(4);
    t_regs;
    t_lock;
    t_strobe;
    t_ctl;
    t_mux;
    t_audio;
    test_done;
  end
endmodule // dpv_video_out_tb_top

// >>> rtl/dpv_ctl_limit.sv
// Pulse filter and transition-rate limiter for one video control signal.
// Assumes raw is already synchronised and tick marks one pixel clock.
`timescale 1ns/1ps
module dpv_ctl_limit (
  // System
  input wire logic clock,
  input wire logic rst,
  // Pixel timing and configuration
  input wire logic tick,
  input wire logic filter_en,
  input wire logic max_two,
  // Signal
  input wire logic raw,
  output logic q
);
  logic cand;
  logic [7:0] stab;
  logic want;
  logic [7:0] age_a;
  logic [7:0] age_b;
  logic allow;
  logic next_cand;
  logic [7:0] next_stab;
  logic next_want;
  logic [7:0] next_age_a;
  logic [7:0] next_age_b;
  logic next_q;

  function automatic logic [7:0] age_inc(input logic [7:0] a);
    age_inc = (a >= dpv_pkg::WIN_PCLK) ? a : 8'(a + 8'h01);
  endfunction

  always_comb begin
    next_cand = cand;
    next_stab = stab;
    next_want = want;
    next_age_a = age_a;
    next_age_b = age_b;
    next_q = q;
    allow = max_two ? (age_b >= dpv_pkg::WIN_PCLK) : (age_a >= dpv_pkg::WIN_PCLK);
    if (tick) begin
      if (raw != cand) begin
        next_cand = raw;
        next_stab = 8'h01;
      end else if (stab < dpv_pkg::FILT_MIN_PCLK) begin
        next_stab = 8'(stab + 8'h01);
      end
      if (!filter_en) begin
        next_want = raw;
      end else if (next_stab >= dpv_pkg::FILT_MIN_PCLK) begin
        next_want = next_cand;
      end
      next_age_a = age_inc(age_a);
      next_age_b = age_inc(age_b);
      if (want != q && allow) begin
        next_q = want;
        next_age_a = 8'h00;
        next_age_b = age_inc(age_a);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cand <= 1'b0;
      stab <= dpv_pkg::FILT_MIN_PCLK;
      want <= 1'b0;
      age_a <= dpv_pkg::WIN_PCLK;
      age_b <= dpv_pkg::WIN_PCLK;
      q <= 1'b0;
    end else begin
      cand <= next_cand;
      stab <= next_stab;
      want <= next_want;
      age_a <= next_age_a;
      age_b <= next_age_b;
      q <= next_q;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_fresh_change;
    tick && filter_en && raw != cand;
  endsequence

  AST_FILT_NO_SHORT: assert property (s_fresh_change |=> want == $past(want))
    else $error("filtered signal accepted a fresh change at once");
  AST_NOFILT_PASS: assert property (tick && !filter_en |=> want == $past(raw))
    else $error("unfiltered signal did not follow its input");
  AST_TWO_PER_WIN: assert property (max_two && $changed(q) |->
      $past(age_b) >= dpv_pkg::WIN_PCLK)
    else $error("more than two transitions in the window");
  AST_ONE_PER_WIN: assert property (!max_two && $changed(q) |->
      $past(age_a) >= dpv_pkg::WIN_PCLK)
    else $error("more than one transition in the window");
endmodule // dpv_ctl_limit

// >>> rtl/dpv_pkg.sv
// Constants, field layouts and carriers for the parallel video output stage.
// Assumes a 50 MHz system clock and an APB master with 32-bit data.
package dpv_pkg;
  // Pixel-clock counts for control-signal shaping
  localparam logic [7:0] FILT_MIN_PCLK = 8'h03;
  localparam logic [7:0] WIN_PCLK = 8'h82;
  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_GPO = 12'h004;
  localparam logic [11:0] ADDR_GPIO = 12'h008;
  localparam logic [11:0] ADDR_STAT = 12'h00c;
  // Control register fields
  localparam int CTRL_W = 6;
  localparam int STROBE_BIT = 0;
  localparam int FILT_BIT = 1;
  localparam int MODE18_BIT = 2;
  localparam int MCLK_LSB = 3;
  localparam int INTMODE_BIT = 5;
  localparam logic [5:0] CTRL_RST = 6'h02;
  // Register-driven output fields, outputs 4..8 in bits 0..4
  localparam int GPO_N = 5;
  localparam int GPO_VAL_LSB = 0;
  localparam int GPO_SEL_LSB = 8;
  localparam logic [4:0] GPO_RST = 5'h00;
  // General I/O fields
  localparam int GPIO_N = 4;
  localparam int GPIO_OUT_LSB = 0;
  localparam int GPIO_DIR_LSB = 4;
  localparam logic [3:0] GPIO_RST = 4'h0;
  // Status fields
  localparam int ST_LOCK_BIT = 0;
  localparam int ST_PWR_BIT = 1;
  localparam int ST_INT_BIT = 2;
  localparam int ST_MODE18_BIT = 3;
  localparam int ST_GPIN_LSB = 4;
  // Audio clock divider width; bit clock is the top bit
  localparam int AUD_DIV_W = 3;
  localparam logic [2:0] AUD_FALL = 3'h7;
  // Master clock ratio to the audio bit clock
  typedef enum logic [1:0] {
    MCLK_X1 = 2'h0,
    MCLK_X2 = 2'h1,
    MCLK_X4 = 2'h2
  } dpv_mclk_e;
  // Recovered pixel from the receive path
  typedef struct packed {
    logic [23:0] data;
    logic hs;
    logic vs;
    logic de;
  } dpv_pixel_s;
  // Video pins, used for both level and enable
  typedef struct packed {
    logic [23:0] data;
    logic hs;
    logic vs;
    logic de;
    logic pclk;
  } dpv_vid_pins_s;
  // Audio pins, used for both level and enable
  typedef struct packed {
    logic bclk;
    logic wc;
    logic da;
    logic mclk;
  } dpv_aud_pins_s;
endpackage

// >>> rtl/dpv_video_out.sv
// Parallel video and audio output stage with APB configuration registers.
// Assumes pixel inputs and pins are asynchronous; audio inputs share clock.
//
// How it works
// - With filter on, horizontal sync and enable pulses under three pixel clocks are dropped.
// - With filter off, sync and enable follow the input with no pulse minimum.
// - Horizontal sync and enable make at most two transitions per 130 pixel clocks.
// - Vertical sync makes at most one transition per 130 pixel clocks.
// - A control bit picks which pixel clock edge strobes the data.
// - Audio master clock runs at one, two or four times the bit clock.
// - Data bits 0, 1, 8 and 9 serve as general I/O 0 to 3.
// - General I/O exists only in 18-bit mode, set by pin or register.
// - Data bit 16 may be output 4; bit 17 may be audio data or output 5.
// - In 18-bit mode data bit 17 carries the second audio data stream unless output 5 is selected.
// - Audio bit clock, word clock and data may be outputs 8, 7, 6.
// - Outputs 4 to 8 take their levels from a control register.
// - Powered down, all outputs float and clock recovery stops.
// - Interrupt input shares a pin with self-test clock select, one at a time.
// - While unlocked, output drive follows the output enable pin, except general I/O pins in 18-bit mode, which follow their direction bits.
// - Once locked, all parallel outputs are driven, except general I/O pins in 18-bit mode, which follow their direction bits.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module dpv_video_out (
  // System
  input wire logic clock,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receive path, recovered pixel clock domain
  input wire logic pclk_in,
  input wire dpv_pkg::dpv_pixel_s rx_pixel,
  // Receive path audio, system clock domain
  input wire logic aud_wc_in,
  input wire logic aud_da_in,
  input wire logic aud_db_in,
  // Control pins
  input wire logic power_down_bar,
  input wire logic output_enable_pin,
  input wire logic lock_in,
  input wire logic mode_select_pin,
  input wire logic shared_int_pin,
  input wire logic [3:0] gpio_in,
  // Video pins
  output dpv_pkg::dpv_vid_pins_s vid_out,
  output dpv_pkg::dpv_vid_pins_s vid_oe,
  // Audio pins
  output dpv_pkg::dpv_aud_pins_s aud_out,
  output dpv_pkg::dpv_aud_pins_s aud_oe,
  // Status and side outputs
  output logic lock_out,
  output logic pll_enable,
  output logic selftest_clock_select
);
  localparam int SY_W = 37;

  logic [SY_W-1:0] sy_meta;
  logic [SY_W-1:0] sy;
  logic pclk_s;
  dpv_pkg::dpv_pixel_s pix_s;
  logic pwr_up_s;
  logic out_en_s;
  logic lock_s;
  logic mode_s;
  logic int_s;
  logic [3:0] gpin_s;
  logic pclk_d;
  logic tick;

  logic [dpv_pkg::CTRL_W-1:0] ctrl;
  logic [4:0] gpo_val;
  logic [4:0] gpo_sel;
  logic [3:0] gpio_out;
  logic [3:0] gpio_dir;
  logic [dpv_pkg::CTRL_W-1:0] next_ctrl;
  logic [4:0] next_gpo_val;
  logic [4:0] next_gpo_sel;
  logic [3:0] next_gpio_out;
  logic [3:0] next_gpio_dir;
  logic [31:0] next_prdata;
  logic hit;
  logic mode18;
  dpv_pkg::dpv_mclk_e mclk_ratio;

  logic [23:0] pix_q;
  logic [23:0] next_pix_q;
  logic hs_l;
  logic vs_l;
  logic de_l;
  logic [2:0] aud_cnt;
  logic aud_wc_q;
  logic aud_da_q;
  logic aud_db_q;
  logic [2:0] next_aud_cnt;
  logic next_aud_wc_q;
  logic next_aud_da_q;
  logic next_aud_db_q;
  logic drv_en;
  dpv_pkg::dpv_vid_pins_s next_vid_out;
  dpv_pkg::dpv_vid_pins_s next_vid_oe;
  dpv_pkg::dpv_aud_pins_s next_aud_out;
  dpv_pkg::dpv_aud_pins_s next_aud_oe;

  function automatic logic [31:0] reg_read(input logic [11:0] a, input logic [31:0] st,
                                          input logic [31:0] c, input logic [31:0] g,
                                          input logic [31:0] io);
    unique case (a)
      dpv_pkg::ADDR_CTRL: reg_read = c;
      dpv_pkg::ADDR_GPO: reg_read = g;
      dpv_pkg::ADDR_GPIO: reg_read = io;
      dpv_pkg::ADDR_STAT: reg_read = st;
      default: reg_read = 32'h0000_0000;
    endcase
  endfunction

  // Two-flop synchroniser for every asynchronous input
  always_ff @(posedge clock) begin
    if (rst) begin
      sy_meta <= '0;
      sy <= '0;
    end else begin
      sy_meta <= {pclk_in, rx_pixel, power_down_bar, output_enable_pin, lock_in,
                  mode_select_pin, shared_int_pin, gpio_in};
      sy <= sy_meta;
    end
  end

  assign {pclk_s, pix_s, pwr_up_s, out_en_s, lock_s, mode_s, int_s, gpin_s} = sy;
  assign tick = pclk_s & ~pclk_d;

  // Register access
  assign hit = (paddr == dpv_pkg::ADDR_CTRL) || (paddr == dpv_pkg::ADDR_GPO) ||
               (paddr == dpv_pkg::ADDR_GPIO) || (paddr == dpv_pkg::ADDR_STAT);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign mode18 = mode_s | ctrl[dpv_pkg::MODE18_BIT];
  assign mclk_ratio = dpv_pkg::dpv_mclk_e'(ctrl[dpv_pkg::MCLK_LSB +: 2]);

  always_comb begin
    next_ctrl = ctrl;
    next_gpo_val = gpo_val;
    next_gpo_sel = gpo_sel;
    next_gpio_out = gpio_out;
    next_gpio_dir = gpio_dir;
    next_prdata = prdata;
    if (psel && !penable) begin
      next_prdata = pwrite ? 32'h0000_0000 : reg_read(paddr,
        32'({gpin_s & {4{mode18}}, mode18, int_s & ctrl[dpv_pkg::INTMODE_BIT], pwr_up_s, lock_s}),
        32'(ctrl), 32'({gpo_sel, 3'h0, gpo_val}), 32'({gpio_dir, gpio_out}));
    end
    if (psel && penable && pwrite) begin
      unique case (paddr)
        dpv_pkg::ADDR_CTRL: next_ctrl = pwdata[dpv_pkg::CTRL_W-1:0];
        dpv_pkg::ADDR_GPO: begin
          next_gpo_val = pwdata[dpv_pkg::GPO_VAL_LSB +: dpv_pkg::GPO_N];
          next_gpo_sel = pwdata[dpv_pkg::GPO_SEL_LSB +: dpv_pkg::GPO_N];
        end
        dpv_pkg::ADDR_GPIO: begin
          next_gpio_out = pwdata[dpv_pkg::GPIO_OUT_LSB +: dpv_pkg::GPIO_N];
          next_gpio_dir = pwdata[dpv_pkg::GPIO_DIR_LSB +: dpv_pkg::GPIO_N];
        end
        default: next_ctrl = ctrl;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl <= dpv_pkg::CTRL_RST;
      gpo_val <= dpv_pkg::GPO_RST;
      gpo_sel <= dpv_pkg::GPO_RST;
      gpio_out <= dpv_pkg::GPIO_RST;
      gpio_dir <= dpv_pkg::GPIO_RST;
      prdata <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      gpo_val <= next_gpo_val;
      gpo_sel <= next_gpo_sel;
      gpio_out <= next_gpio_out;
      gpio_dir <= next_gpio_dir;
      prdata <= next_prdata;
    end
  end

  // Control signal shaping
  dpv_ctl_limit u_hs (
    .clock(clock), .rst(rst), .tick(tick), .filter_en(ctrl[dpv_pkg::FILT_BIT]),
    .max_two(1'b1), .raw(pix_s.hs), .q(hs_l)
  );
  dpv_ctl_limit u_de (
    .clock(clock), .rst(rst), .tick(tick), .filter_en(ctrl[dpv_pkg::FILT_BIT]),
    .max_two(1'b1), .raw(pix_s.de), .q(de_l)
  );
  dpv_ctl_limit u_vs (
    .clock(clock), .rst(rst), .tick(tick), .filter_en(1'b0),
    .max_two(1'b0), .raw(pix_s.vs), .q(vs_l)
  );

  // Pixel data, audio clocking and pin muxing
  assign drv_en = pwr_up_s & (lock_s | out_en_s);

  always_comb begin
    next_pix_q = tick ? pix_s.data : pix_q;
    next_aud_cnt = 3'(aud_cnt + 3'h1);
    next_aud_wc_q = aud_wc_q;
    next_aud_da_q = aud_da_q;
    next_aud_db_q = aud_db_q;
    if (aud_cnt == dpv_pkg::AUD_FALL) begin
      next_aud_wc_q = aud_wc_in;
      next_aud_da_q = aud_da_in;
      next_aud_db_q = aud_db_in;
    end
    next_vid_out.data = lock_s ? pix_q : 24'h00_0000;
    next_vid_out.hs = lock_s & hs_l;
    next_vid_out.vs = lock_s & vs_l;
    next_vid_out.de = lock_s & de_l;
    next_vid_out.pclk = lock_s & (pclk_d ^ ctrl[dpv_pkg::STROBE_BIT]);
    next_vid_oe = {$bits(dpv_pkg::dpv_vid_pins_s){drv_en}};
    if (mode18) begin
      {next_vid_out.data[9:8], next_vid_out.data[1:0]} = gpio_out;
      {next_vid_oe.data[9:8], next_vid_oe.data[1:0]} = gpio_dir & {4{pwr_up_s}};
      next_vid_out.data[17] = aud_db_q;
    end
    if (gpo_sel[0]) begin
      next_vid_out.data[16] = gpo_val[0];
    end
    if (gpo_sel[1]) begin
      next_vid_out.data[17] = gpo_val[1];
    end
    next_aud_out.bclk = gpo_sel[4] ? gpo_val[4] : aud_cnt[2];
    next_aud_out.wc = gpo_sel[3] ? gpo_val[3] : aud_wc_q;
    next_aud_out.da = gpo_sel[2] ? gpo_val[2] : aud_da_q;
    unique case (mclk_ratio)
      dpv_pkg::MCLK_X2: next_aud_out.mclk = aud_cnt[1];
      dpv_pkg::MCLK_X4: next_aud_out.mclk = aud_cnt[0];
      default: next_aud_out.mclk = aud_cnt[2];
    endcase
    next_aud_oe = {$bits(dpv_pkg::dpv_aud_pins_s){drv_en}};
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pclk_d <= 1'b0;
      pix_q <= 24'h00_0000;
      aud_cnt <= 3'h0;
      aud_wc_q <= 1'b0;
      aud_da_q <= 1'b0;
      aud_db_q <= 1'b0;
      vid_out <= '0;
      vid_oe <= '0;
      aud_out <= '0;
      aud_oe <= '0;
      lock_out <= 1'b0;
      pll_enable <= 1'b0;
      selftest_clock_select <= 1'b0;
    end else begin
      pclk_d <= pclk_s;
      pix_q <= next_pix_q;
      aud_cnt <= next_aud_cnt;
      aud_wc_q <= next_aud_wc_q;
      aud_da_q <= next_aud_da_q;
      aud_db_q <= next_aud_db_q;
      vid_out <= next_vid_out;
      vid_oe <= next_vid_oe;
      aud_out <= next_aud_out;
      aud_oe <= next_aud_oe;
      lock_out <= lock_s & pwr_up_s;
      pll_enable <= pwr_up_s;
      selftest_clock_select <= int_s & ~ctrl[dpv_pkg::INTMODE_BIT];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_power_off;
    !pwr_up_s;
  endsequence

  AST_PD_FLOAT: assert property (s_power_off |=>
      vid_oe == '0 && aud_oe == '0 && !pll_enable)
    else $error("outputs driven while powered down");
  AST_UNLOCK_OE_PIN: assert property (pwr_up_s && !lock_s |=>
      vid_oe.de == $past(out_en_s))
    else $error("unlocked drive does not follow output enable");
  AST_LOCK_DRIVE: assert property (pwr_up_s && lock_s |=>
      vid_oe.hs && vid_oe.pclk && aud_oe.bclk)
    else $error("locked outputs not driven");
  AST_NO_GPIO_18: assert property (!mode18 && !gpo_sel[0] && lock_s |=>
      vid_out.data[0] == $past(pix_q[0]))
    else $error("general I/O active outside 18-bit mode");
  AST_GPIO_OUT: assert property (mode18 |=> vid_out.data[8] == $past(gpio_out[2]))
    else $error("general I/O 2 not on data bit 8");
  AST_BIT17_AUDIO: assert property (mode18 && !gpo_sel[1] |=>
      vid_out.data[17] == $past(aud_db_q))
    else $error("second audio data missing on bit 17");
  AST_GPO5_WINS: assert property (gpo_sel[1] |=> vid_out.data[17] == $past(gpo_val[1]))
    else $error("bit 17 drives two functions");
  AST_GPO8_BCLK: assert property (gpo_sel[4] |=> aud_out.bclk == $past(gpo_val[4]))
    else $error("bit clock pin ignores output 8");
  AST_MCLK_X4: assert property ((mclk_ratio == dpv_pkg::MCLK_X4) [*2] |=>
      aud_out.mclk != $past(aud_out.mclk))
    else $error("master clock not at four times bit clock");
  AST_STROBE: assert property (lock_s && $changed(ctrl[dpv_pkg::STROBE_BIT]) &&
      $stable(pclk_d) |=> $changed(vid_out.pclk))
    else $error("strobe edge select has no effect");
  AST_SHARED_INT: assert property (ctrl[dpv_pkg::INTMODE_BIT] |=> !selftest_clock_select)
    else $error("shared pin active in both functions");
endmodule // dpv_video_out
